// ---- ecd_pkg.sv ----
// shared constants and types for the 8-bit instruction decoder
package ecd_pkg;

  // ----------------------------------------------------------------
  // widths and register codes
  // ----------------------------------------------------------------
  localparam int DW  = 8;   // data word
  localparam int AW  = 14;  // program address
  localparam int HW  = 6;   // used bits of the high address byte
  localparam int RFN = 7;   // accumulator plus six index registers
  localparam logic [2:0] RF_ACC = 3'h0;
  localparam logic [2:0] RF_HI  = 3'h5;
  localparam logic [2:0] RF_LO  = 3'h6;
  localparam logic [2:0] RF_MEM = 3'h7;

  // ----------------------------------------------------------------
  // condition select and operation codes
  // ----------------------------------------------------------------
  localparam logic [1:0] COND_CARRY  = 2'h0;
  localparam logic [1:0] COND_ZERO   = 2'h1;
  localparam logic [1:0] COND_SIGN   = 2'h2;
  localparam logic [1:0] COND_PARITY = 2'h3;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_ADC = 3'h1;
  localparam logic [2:0] OP_SUB = 3'h2;
  localparam logic [2:0] OP_SUB_BORROW = 3'h3;
  localparam logic [2:0] OP_AND = 3'h4;
  localparam logic [2:0] OP_XOR = 3'h5;
  localparam logic [2:0] OP_OR  = 3'h6;
  localparam logic [2:0] OP_COMPARE = 3'h7;
  localparam logic [2:0] ROT_LEFT      = 3'h0;
  localparam logic [2:0] ROT_RIGHT     = 3'h1;
  localparam logic [2:0] ROT_LEFT_CY   = 3'h2;
  localparam logic [2:0] ROT_RIGHT_CY  = 3'h3;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_ACC    = 2'h2;
  localparam logic [1:0] REG_PC_LO  = 2'h3;
  localparam int         CTRL_RUN   = 0;
  localparam logic [DW-1:0] CTRL_RST = 8'h01;

  // ----------------------------------------------------------------
  // least state counts per instruction
  // ----------------------------------------------------------------
  localparam logic [3:0] MIN_STOP     = 4'h4;
  localparam logic [3:0] MIN_NOP      = 4'h4;
  localparam logic [3:0] MIN_REG      = 4'h5;
  localparam logic [3:0] MIN_MEM_RD   = 4'h8;
  localparam logic [3:0] MIN_MEM_WR   = 4'h7;
  localparam logic [3:0] MIN_IMM      = 4'h8;
  localparam logic [3:0] MIN_IMM_MEM  = 4'h9;
  localparam logic [3:0] MIN_JUMP     = 4'hb;
  localparam logic [3:0] MIN_JUMP_NOT = 4'h9;
  localparam logic [3:0] MIN_RET_NOT  = 4'h3;
  localparam logic [3:0] MIN_IN       = 4'h8;
  localparam logic [3:0] MIN_OUT      = 4'h6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0, ST_FWAIT = 4'h1, ST_EXEC = 4'h3, ST_B2 = 4'h2,
    ST_B2W   = 4'h6, ST_B3    = 4'h7, ST_B3W  = 4'h5, ST_MRD = 4'h4,
    ST_MRDW  = 4'hc, ST_MWR   = 4'hd, ST_PAD  = 4'hf, ST_STOP = 4'he
  } ecd_state_t;

  typedef enum logic [1:0] {K_ARITH, K_INC, K_DEC, K_ROT} ecd_kind_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic parity;
  } ecd_flags_t;

endpackage : ecd_pkg

// ---- ecd_alu.sv ----
// arithmetic, logic, increment and rotate unit with flag update
`timescale 1ns/1ps
module ecd_alu import ecd_pkg::*; (
  // operation select
  input  ecd_kind_t          kind,
  input  wire logic [2:0]    op,
  // operands
  input  wire logic [DW-1:0] a,
  input  wire logic [DW-1:0] b,
  input  ecd_flags_t         flags_in,
  // results
  output logic [DW-1:0]      result,
  output ecd_flags_t         flags_out,
  output logic               write_back
);

  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  always_comb begin
    logic [DW:0] wide;
    wide       = '0;
    result     = a;
    write_back = 1'b1;
    flags_out  = flags_in;
    case (kind)
      K_ARITH: begin
        case (op)
          OP_ADD: wide = {1'b0, a} + {1'b0, b};
          OP_ADC: wide = {1'b0, a} + {1'b0, b} + {8'h00, flags_in.carry};
          // a borrow shows in the ninth bit
          OP_SUB: wide = {1'b0, a} - {1'b0, b};
          OP_SUB_BORROW: wide = {1'b0, a} - {1'b0, b} - {8'h00, flags_in.carry};
          OP_AND: wide = {1'b0, a & b};
          OP_XOR: wide = {1'b0, a ^ b};
          OP_OR:  wide = {1'b0, a | b};
          default: begin
            // compare: flags only
            wide       = {1'b0, a} - {1'b0, b};
            write_back = 1'b0;
          end
        endcase
        result          = wide[DW-1:0];
        flags_out.carry = wide[DW];
      end
      K_INC: begin
        result = a + 8'h01;
      end
      K_DEC: begin
        result = a - 8'h01;
      end
      default: begin
        case (op)
          ROT_LEFT: begin
            result          = {a[DW-2:0], a[DW-1]};
            flags_out.carry = a[DW-1];
          end
          ROT_RIGHT: begin
            result          = {a[0], a[DW-1:1]};
            flags_out.carry = a[0];
          end
          ROT_LEFT_CY: begin
            result          = {a[DW-2:0], flags_in.carry};
            flags_out.carry = a[DW-1];
          end
          default: begin
            result          = {flags_in.carry, a[DW-1:1]};
            flags_out.carry = a[0];
          end
        endcase
      end
    endcase
    // zero, sign and even parity of the result
    if (kind != K_ROT) begin
      flags_out.zero   = (result == '0);
      flags_out.sign   = result[DW-1];
      flags_out.parity = ~^result;
    end
  end

endmodule : ecd_alu

// ---- ecd_stack.sv ----
// circular return address stack
`timescale 1ns/1ps
module ecd_stack import ecd_pkg::*; #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // stack control
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_addr,
  output logic [AW-1:0]      top_addr
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0]              ptr;
    logic [DEPTH-1:0][AW-1:0]   mem;
  } ecd_stack_t;

  ecd_stack_t s_q;
  ecd_stack_t s_d;

  // ----------------------------------------------------------------
  // push writes at the pointer, pop steps back; overflow wraps
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.ptr] = push_addr;
      s_d.ptr          = s_q.ptr + 1'b1;
    end else if (pop) begin
      s_d.ptr = s_q.ptr - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign top_addr = s_q.mem[PW'(s_q.ptr - 1'b1)];

endmodule : ecd_stack

// ---- ecd_decoder.sv ----
// instruction fetch, decode and execute core for the 8-bit processor
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module ecd_decoder import ecd_pkg::*; #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // program and data memory
  output logic [AW-1:0]      mem_addr,
  output logic               mem_rd,
  output logic               mem_wr,
  output logic [DW-1:0]      mem_wdata,
  input  wire logic [DW-1:0] mem_rdata,
  // input ports
  output logic [2:0]         in_port,
  output logic               in_rd,
  input  wire logic [DW-1:0] in_data,
  // output ports
  output logic [4:0]         out_port,
  output logic               out_wr,
  output logic [DW-1:0]      out_data,
  // wake from the stopped state
  input  wire logic          intr_req,
  // register port
  input  wire logic [1:0]    reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [DW-1:0]      reg_rdata,
  // status
  output logic               halted
);

  typedef struct packed {
    ecd_state_t              st;
    logic [AW-1:0]           pc;
    logic [DW-1:0]           ir;
    logic [DW-1:0]           b2;
    logic [DW-1:0]           wdata;
    logic [DW-1:0]           ctrl;
    logic [DW-1:0]           rdata;
    logic [DW-1:0]           odata;
    logic [4:0]              oport;
    logic                    owr;
    logic [RFN-1:0][DW-1:0]  rf;
    ecd_flags_t              fl;
    logic [3:0]              cnt;
    logic [3:0]              min;
    logic                    stop;
  } ecd_core_t;

  ecd_core_t      s_q;
  ecd_core_t      s_d;
  ecd_kind_t      kind;
  logic [DW-1:0]  alu_a;
  logic [DW-1:0]  alu_b;
  logic [DW-1:0]  alu_res;
  ecd_flags_t     alu_fl;
  logic           alu_wb;
  logic           push;
  logic           pop;
  logic [AW-1:0]  top_addr;
  logic           cond_flag;
  logic           taken;
  logic [1:0]     cls;
  logic [2:0]     dfield;
  logic [2:0]     sfield;
  logic [AW-1:0]  target;
  logic           is_input;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // codes 000..110 address the register file
  function automatic logic [DW-1:0] rd_reg(input logic [RFN-1:0][DW-1:0] rf,
                                           input logic [2:0] idx);
    rd_reg = (idx == RF_MEM) ? '0 : rf[idx];
  endfunction : rd_reg

  // least state count decided from the opcode alone
  function automatic logic [3:0] min_for(input logic [DW-1:0] op);
    min_for = MIN_NOP;
    case (op[7:6])
      2'b11: begin
        if (op == 8'hff) min_for = MIN_STOP;
        else if (op[2:0] == RF_MEM) min_for = MIN_MEM_RD;
        else if (op[5:3] == RF_MEM) min_for = MIN_MEM_WR;
        else min_for = MIN_REG;
      end
      2'b10: begin
        min_for = (op[2:0] == RF_MEM) ? MIN_MEM_RD : MIN_REG;
      end
      2'b01: begin
        if (op[0]) min_for = (op[5:4] == 2'b00) ? MIN_IN : MIN_OUT;
        else min_for = MIN_JUMP;
      end
      default: begin
        case (op[2:0])
          3'b000, 3'b001: min_for = (op[5:3] == RF_ACC) ? MIN_STOP : MIN_REG;
          3'b100: min_for = MIN_IMM;
          3'b110: min_for = (op[5:3] == RF_MEM) ? MIN_IMM_MEM : MIN_IMM;
          default: min_for = MIN_REG;
        endcase
      end
    endcase
  endfunction : min_for

  // ----------------------------------------------------------------
  // opcode fields and condition test
  // ----------------------------------------------------------------
  assign cls    = s_q.ir[7:6];
  assign dfield = s_q.ir[5:3];
  assign sfield = s_q.ir[2:0];
  // top two bits of the third byte dropped
  assign target = {mem_rdata[HW-1:0], s_q.b2};

  always_comb begin
    case (s_q.ir[4:3])
      COND_CARRY: cond_flag = s_q.fl.carry;
      COND_ZERO:  cond_flag = s_q.fl.zero;
      COND_SIGN:  cond_flag = s_q.fl.sign;
      default:    cond_flag = s_q.fl.parity;
    endcase
  end

  // bit 5 picks true or false sense
  assign taken = s_q.ir[5] ? cond_flag : !cond_flag;

  // ----------------------------------------------------------------
  // ALU operand selection
  // ----------------------------------------------------------------
  always_comb begin
    kind = K_ARITH;
    if (cls == 2'b00) begin
      case (sfield)
        3'b000:  kind = K_INC;
        3'b001:  kind = K_DEC;
        3'b010:  kind = K_ROT;
        default: kind = K_ARITH;
      endcase
    end
  end

  // increment and decrement work on the named register
  assign alu_a = (kind == K_INC || kind == K_DEC) ? rd_reg(s_q.rf, dfield) : s_q.rf[RF_ACC];
  // immediate and memory operands come straight off the bus
  assign alu_b = (s_q.st == ST_B2W || s_q.st == ST_MRDW) ? mem_rdata : rd_reg(s_q.rf, sfield);

  ecd_alu u_alu (
    .kind       (kind),
    .op         (dfield),
    .a          (alu_a),
    .b          (alu_b),
    .flags_in   (s_q.fl),
    .result     (alu_res),
    .flags_out  (alu_fl),
    .write_back (alu_wb)
  );

  ecd_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (push),
    .pop       (pop),
    .push_addr (s_q.pc),
    .top_addr  (top_addr)
  );

  // port read happens in the execute cycle
  assign is_input = (cls == 2'b01) && s_q.ir[0] && (s_q.ir[5:4] == 2'b00);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    push    = 1'b0;
    pop     = 1'b0;
    s_d.owr = 1'b0;
    s_d.cnt = (s_q.cnt == 4'hf) ? s_q.cnt : s_q.cnt + 4'h1;

    // register port write and one-cycle read answer
    if (reg_wr && reg_addr == REG_CTRL) begin
      s_d.ctrl = reg_wdata;
    end
    s_d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) s_d.rdata = s_q.ctrl;
      else if (reg_addr == REG_STATUS) s_d.rdata = {3'h0, s_q.st == ST_STOP, s_q.fl};
      else if (reg_addr == REG_ACC) s_d.rdata = s_q.rf[RF_ACC];
      else s_d.rdata = s_q.pc[DW-1:0];
    end

    case (s_q.st)
      ST_FETCH: begin
        s_d.cnt = 4'h1;
        s_d.pc  = s_q.pc + 14'h1;
        s_d.st  = ST_FWAIT;
      end
      ST_FWAIT: begin
        s_d.ir  = mem_rdata;
        s_d.min = min_for(mem_rdata);
        s_d.st  = ST_EXEC;
      end
      ST_EXEC: begin
        s_d.st = ST_PAD;
        case (cls)
          2'b11: begin
            if (s_q.ir == 8'hff) begin
              s_d.stop = 1'b1;
            end else if (sfield == RF_MEM) begin
              s_d.st = ST_MRD;
            end else if (dfield == RF_MEM) begin
              s_d.wdata = rd_reg(s_q.rf, sfield);
              s_d.st    = ST_MWR;
            end else begin
              s_d.rf[dfield] = rd_reg(s_q.rf, sfield);
            end
          end
          2'b10: begin
            if (sfield == RF_MEM) begin
              s_d.st = ST_MRD;
            end else begin
              if (alu_wb) s_d.rf[RF_ACC] = alu_res;
              s_d.fl = alu_fl;
            end
          end
          2'b01: begin
            if (!s_q.ir[0]) begin
              s_d.st = ST_B2;
            end else if (is_input) begin
              s_d.rf[RF_ACC] = in_data;
            end else begin
              // accumulator to the five-bit port number
              s_d.oport = s_q.ir[5:1];
              s_d.odata = s_q.rf[RF_ACC];
              s_d.owr   = 1'b1;
            end
          end
          default: begin
            case (sfield)
              3'b000, 3'b001: begin
                if (dfield == RF_ACC) begin
                  s_d.stop = 1'b1;
                end else if (dfield != RF_MEM) begin
                  s_d.rf[dfield] = alu_res;
                  s_d.fl         = alu_fl;
                end
              end
              3'b010: begin
                // only the four rotate codes act
                // the other four codes fall through as no-ops
                if (!s_q.ir[5]) begin
                  s_d.rf[RF_ACC] = alu_res;
                  s_d.fl         = alu_fl;
                end
              end
              3'b011: begin
                if (taken) begin
                  s_d.pc = top_addr;
                  pop    = 1'b1;
                end else begin
                  s_d.min = MIN_RET_NOT;
                end
              end
              3'b101: begin
                push   = 1'b1;
                s_d.pc = AW'({dfield, 3'b000});
              end
              3'b111: begin
                s_d.pc = top_addr;
                pop    = 1'b1;
              end
              default: begin
                s_d.st = ST_B2;
              end
            endcase
          end
        endcase
      end
      ST_B2: begin
        s_d.pc = s_q.pc + 14'h1;
        s_d.st = ST_B2W;
      end
      ST_B2W: begin
        s_d.b2 = mem_rdata;
        s_d.st = ST_PAD;
        if (cls == 2'b01) begin
          s_d.st = ST_B3;
        end else if (sfield == 3'b110) begin
          // immediate load, memory when the destination is 111
          if (dfield == RF_MEM) begin
            s_d.wdata = mem_rdata;
            s_d.st    = ST_MWR;
          end else begin
            s_d.rf[dfield] = mem_rdata;
          end
        end else begin
          // immediate forms of the ALU group
          if (alu_wb) s_d.rf[RF_ACC] = alu_res;
          s_d.fl = alu_fl;
        end
      end
      ST_B3: begin
        s_d.pc = s_q.pc + 14'h1;
        s_d.st = ST_B3W;
      end
      ST_B3W: begin
        s_d.st = ST_PAD;
        if (s_q.ir[2] || taken) begin
          push   = s_q.ir[1];
          s_d.pc = target;
        end else begin
          s_d.min = MIN_JUMP_NOT;
        end
      end
      ST_MRD: begin
        s_d.st = ST_MRDW;
      end
      ST_MRDW: begin
        s_d.st = ST_PAD;
        if (cls == 2'b11) begin
          s_d.rf[dfield] = mem_rdata;
        end else begin
          if (alu_wb) s_d.rf[RF_ACC] = alu_res;
          s_d.fl = alu_fl;
        end
      end
      ST_MWR: begin
        s_d.st = ST_PAD;
      end
      ST_PAD: begin
        // hold until the least state count has run out
        if (s_q.cnt >= s_q.min - 4'h1) begin
          if (s_q.stop) s_d.st = ST_STOP;
          else if (s_q.ctrl[CTRL_RUN]) s_d.st = ST_FETCH;
        end
      end
      ST_STOP: begin
        if (intr_req) begin
          s_d.stop = 1'b0;
          s_d.st   = ST_FETCH;
        end
      end
      default: begin
        s_d.st = ST_FETCH;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q      <= '0;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // memory operand at H:L
  assign mem_addr  = (s_q.st == ST_MRD || s_q.st == ST_MWR) ?
                     {s_q.rf[RF_HI][HW-1:0], s_q.rf[RF_LO]} : s_q.pc;
  assign mem_rd    = (s_q.st == ST_FETCH) || (s_q.st == ST_B2) ||
                     (s_q.st == ST_B3) || (s_q.st == ST_MRD);
  assign mem_wr    = (s_q.st == ST_MWR);
  assign mem_wdata = s_q.wdata;
  assign in_port   = s_q.ir[3:1];
  assign in_rd     = (s_q.st == ST_EXEC) && is_input;
  assign out_port  = s_q.oport;
  assign out_wr    = s_q.owr;
  assign out_data  = s_q.odata;
  assign reg_rdata = s_q.rdata;
  assign halted    = (s_q.st == ST_STOP);

endmodule : ecd_decoder

// ---- ecd_decoder_props.sv ----
// assertion checker for the decoder ports
`timescale 1ns/1ps
module ecd_decoder_props import ecd_pkg::*; (
  // clock and reset
  input wire logic          clk,
  input wire logic          reset_n,
  // memory and port strobes
  input wire logic          mem_rd,
  input wire logic          mem_wr,
  input wire logic          in_rd,
  input wire logic          out_wr,
  input wire logic [4:0]    out_port,
  input wire logic [DW-1:0] out_data,
  // wake, register port, status
  input wire logic          intr_req,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic          halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bus_spacing: assert property ((mem_rd || mem_wr) |=> !(mem_rd || mem_wr))
    else $error("memory accesses too close");
  a_out_gap: assert property (out_wr |=> !out_wr [*5])
    else $error("output writes too close");
  a_out_hold: assert property (out_wr |=> $stable(out_data) && $stable(out_port))
    else $error("output data not held");
  a_out_port: assert property (out_wr |-> out_port[4:3] != 2'h0)
    else $error("output port with zero group");
  a_in_gap: assert property (in_rd |=> !in_rd [*7])
    else $error("input reads too close");
  a_halt_quiet: assert property (halted |-> !mem_rd && !mem_wr)
    else $error("bus active while stopped");
  a_halt_hold: assert property (halted && !intr_req |=> halted)
    else $error("left stop without wake");
  a_halt_wake: assert property (halted && intr_req |=> !halted ##[0:2] mem_rd)
    else $error("no fetch after wake");
  a_reg_slot: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside its cycle");
  c_out: cover property (out_wr);
  c_in: cover property (in_rd);
  c_wake: cover property (halted && intr_req);
endmodule : ecd_decoder_props

// ---- ecd_mem_model.sv ----
// program and data memory model
`timescale 1ns/1ps
module ecd_mem_model import ecd_pkg::*; (
  // memory bus
  input wire logic          clk,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          mem_rd,
  input wire logic          mem_wr,
  input wire logic [DW-1:0] mem_wdata,
  output logic [DW-1:0]     mem_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // byte answer next cycle, scrambled otherwise
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
endmodule : ecd_mem_model

// ---- ecd_decoder_tb.sv ----
// self-checking testbench for the decoder
`timescale 1ns/1ps
module ecd_decoder_tb import ecd_pkg::*;;
  logic          clk = 1'b0, reset_n = 1'b0, intr_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic          mem_rd, mem_wr, in_rd, out_wr, halted;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] mem_wdata, mem_rdata, in_data, out_data, reg_rdata, v;
  logic [DW-1:0] reg_wdata = 8'h00;
  logic [1:0]    reg_addr = 2'h0;
  logic [2:0]    in_port;
  logic [4:0]    out_port;
  int            num_errors = 0, num_checks = 0, n;
  logic [7:0] prog [32] = '{8'h06, 8'hff, 8'h04, 8'h01, 8'h51, 8'h0e, 8'h7f, 8'h08, 8'hc1, 8'h53, 8'h40,
    8'h20, 8'hc0, 8'h60, 8'h10, 8'hc0, 8'h46, 8'h30, 8'h00, 8'h55, 8'h47, 8'h57, 8'h2e, 8'h00, 8'h36,
    8'h40, 8'hf8, 8'h00, 8'h59, 8'h44, 8'h50, 8'h40};
  // restart target at 0x38 and the second program at 0x50
  logic [7:0] rst_sub [6] = '{8'h5d, 8'h03, 8'h06, 8'h30, 8'h2a, 8'h23};
  logic [7:0] prog2 [14] = '{8'h14, 8'h3c, 8'h1c, 8'h0f, 8'h2c, 8'hff, 8'h5b, 8'h3c, 8'h11, 8'h3d,
    8'ha7, 8'h0a, 8'h5f, 8'h00};
  // input data follows the selected port
  assign in_data = {5'h07, in_port};
  initial forever #50 clk = ~clk;
  ecd_decoder i_ecd_decoder (.clk, .reset_n, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .in_port,
    .in_rd, .in_data, .out_port, .out_wr, .out_data, .intr_req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .halted);
  ecd_mem_model i_ecd_mem_model (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  // ----
  // helpers
  // ----
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic wait_out(logic [4:0] port, logic [7:0] data);
    for (n = 0; n < 300 && out_wr !== 1'b1; n++) @(posedge clk) #1;
    if (n == 300) begin
      num_errors++;
      finish_test();
    end
    chk("out_port", {3'h0, port}, {3'h0, out_port});
    chk("out_data", data, out_data);
    @(posedge clk) #1;
  endtask : wait_out
  task automatic rd_reg(logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr_reg
  // ----
  // scenarios
  // ----
  task automatic sc_prog1();
    wait_out(5'h08, 8'h00);
    wait_out(5'h09, 8'h80);
    wait_out(5'h0a, 8'h01);
    wait_out(5'h0b, 8'h3b);
  endtask : sc_prog1
  task automatic sc_halt();
    for (n = 0; n < 300 && halted !== 1'b1; n++) @(posedge clk) #1;
    chk("halted", 8'h01, {7'h0, halted});
    rd_reg(REG_STATUS, v);
    chk("status", 8'h18, v & 8'h18);
    wr_reg(REG_ACC, 8'h55);
    rd_reg(REG_ACC, v);
    chk("acc", 8'h3b, v);
    rd_reg(REG_CTRL, v);
    chk("ctrl", CTRL_RST, v);
    chk("mem", 8'h3b, i_ecd_mem_model.mem[14'h0040]);
    // wake with run cleared: the core fetches and runs one instruction, then pauses before the next fetch
    wr_reg(REG_CTRL, 8'h00);
    intr_req <= 1'b1;
    @(posedge clk) intr_req <= 1'b0;
    wait_out(5'h0c, 8'h3b);
    repeat (20) @(posedge clk);
    rd_reg(REG_PC_LO, v);
    chk("pc", 8'h1d, v);
    wr_reg(REG_CTRL, CTRL_RST);
  endtask : sc_halt
  task automatic sc_prog2();
    wait_out(5'h0d, 8'h10);
    wait_out(5'h0e, 8'h10);
    wait_out(5'h0f, 8'h18);
  endtask : sc_prog2
  initial begin
    for (int i = 0; i < (1 << AW); i++) i_ecd_mem_model.mem[i] = 8'h00;
    for (int i = 0; i < 32; i++) i_ecd_mem_model.mem[i] = prog[i];
    for (int i = 0; i < 6; i++) i_ecd_mem_model.mem[14'h0038 + i] = rst_sub[i];
    for (int i = 0; i < 14; i++) i_ecd_mem_model.mem[14'h0050 + i] = prog2[i];
    i_ecd_mem_model.mem[14'h0020] = 8'h7f;
    i_ecd_mem_model.mem[14'h0030] = 8'h02;
    i_ecd_mem_model.mem[14'h0031] = 8'h07;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    sc_prog1();
    sc_halt();
    sc_prog2();
    finish_test();
  end
endmodule : ecd_decoder_tb
bind ecd_decoder ecd_decoder_props i_ecd_decoder_props (.clk, .reset_n, .mem_rd, .mem_wr, .in_rd, .out_wr,
  .out_port, .out_data, .intr_req, .reg_rd, .reg_rdata, .halted);
